// ===== hw/sti_pkg.sv
/*
  constants, states and carriers of the thermal sensor serial register front end.
  assumes a 40 MHz core clock and a bus whose pins are already synchronous to it.
*/
package sti_pkg;
  // clock and bus timeout (longest time, so the count rounds down)
  localparam int CLK_HZ = 40_000_000;
  localparam int TIMEOUT_MS = 35;
  localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam logic [6:0] SLAVE_ADDR = 7'h4c;

  // register offsets
  localparam logic [7:0] OFS_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] OFS_REM_MSB = 8'h01;
  localparam logic [7:0] OFS_ALERT = 8'h02;
  localparam logic [7:0] OFS_CONFIG = 8'h03;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_LOCAL_HI = 8'h05;
  localparam logic [7:0] OFS_REM_HI = 8'h07;
  localparam logic [7:0] OFS_REM_LO = 8'h08;
  localparam logic [7:0] OFS_CONFIG_MIR = 8'h09;
  localparam logic [7:0] OFS_RATE_MIR = 8'h0a;
  localparam logic [7:0] OFS_LOCAL_HI_MIR = 8'h0b;
  localparam logic [7:0] OFS_REM_HI_MIR = 8'h0d;
  localparam logic [7:0] OFS_REM_LO_MIR = 8'h0e;
  localparam logic [7:0] OFS_ONE_SHOT = 8'h0f;
  localparam logic [7:0] OFS_REM_LSB = 8'h10;
  localparam logic [7:0] OFS_OFFSET = 8'h11;
  localparam logic [7:0] OFS_FILTER = 8'hbf;

  // values after reset and writable bit masks
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h08;
  localparam logic [7:0] RST_LOCAL_HI = 8'h46;
  localparam logic [7:0] RST_REM_HI = 8'h69;
  localparam logic [7:0] RST_REM_LO = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_FILTER = 8'h00;
  localparam logic [7:0] MASK_CONFIG = 8'he7;
  localparam logic [7:0] MASK_RATE = 8'h0f;
  localparam logic [7:0] MASK_FILTER = 8'h07;

  // field positions
  localparam int CFG_FAULT_QUEUE = 0;
  localparam int CFG_STANDBY = 6;
  localparam int FLT_SEL_LO = 1;
  localparam int ALT_BUSY = 7;
  localparam int ALT_LOCAL_HI = 6;
  localparam int ALT_REM_HI = 4;
  localparam int ALT_REM_LO = 3;
  localparam int ALT_DIODE = 2;

  // filter selections
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_STD = 2'h1;
  localparam logic [1:0] FILT_RSVD = 2'h2;
  localparam logic [1:0] FILT_ENH = 2'h3;
  localparam logic signed [15:0] FILT_CLIP = 16'sh0100;

  // fault queue: channels and required run length
  localparam int NCH = 3;
  localparam logic [1:0] FQ_COUNT = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_ADDR_ACK = 4'h2, ST_CMD = 4'h3, ST_CMD_ACK = 4'h4,
    ST_WDATA = 4'h5, ST_WDATA_ACK = 4'h6, ST_IGNORE = 4'h7, ST_RDATA = 4'h8, ST_RDATA_ACK = 4'h9
  } sti_state_t;

  typedef struct packed {
    logic [7:0] config_r;
    logic [7:0] rate;
    logic [7:0] local_hi;
    logic [7:0] rem_hi;
    logic [7:0] rem_lo;
    logic [7:0] offset;
    logic [7:0] filter;
  } sti_regs_t;
endpackage : sti_pkg

// ===== hw/sti_regif.sv
/*
  serial register front end of a remote-diode thermal sensor: bus slave, register bank,
  remote filter and fault queue.
  assumes scl/sda already synchronous to clk_in and an outside converter that pulses conversion_interval_code_done_in.
*/
`timescale 1ns/1ps
module sti_regif import sti_pkg::*; #(
  parameter int TIMEOUT = TIMEOUT_CYCLES
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // converter side
  input wire logic [7:0] local_temp_in,
  input wire logic [10:0] remote_raw_in,
  input wire logic conversion_interval_code_done_in,
  input wire logic busy_in,
  input wire logic diode_fault_in,
  output logic one_shot_out,
  output logic standby_out,
  output sti_regs_t regs_out,
  output logic [7:0] alert_flags_out
);
  sti_state_t state_reg, state_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next;
  logic oe_reg, oe_next, rw_reg, rw_next, scl_q, sda_q;
  logic [20:0] tmo_reg, tmo_next;
  logic wr_stb, rd_stb;
  sti_regs_t regs_reg, regs_next;
  logic one_shot_reg, one_shot_next;
  logic [7:0] local_reg, local_next;
  logic [12:0] rem_reg, rem_next;
  logic signed [14:0] acc_reg, acc_next;
  logic [3:0] flag_reg, flag_next;
  logic [1:0] cnt_reg [NCH];
  logic [1:0] cnt_next [NCH];
  logic [NCH-1:0] cond, hit;
  logic start_c, stop_c, scl_rise, scl_fall, tmo_hit;

  assign start_c = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c = scl_in & scl_q & ~sda_q & sda_in;
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign tmo_hit = tmo_reg >= 21'(TIMEOUT - 1);

  // mirrors fold onto their physical register
  function automatic logic [7:0] map_addr(input logic [7:0] a);
    case (a)
      OFS_CONFIG_MIR: map_addr = OFS_CONFIG;
      OFS_RATE_MIR: map_addr = OFS_RATE;
      OFS_LOCAL_HI_MIR: map_addr = OFS_LOCAL_HI;
      OFS_REM_HI_MIR: map_addr = OFS_REM_HI;
      OFS_REM_LO_MIR: map_addr = OFS_REM_LO;
      default: map_addr = a;
    endcase
  endfunction : map_addr

  function automatic logic [7:0] read_byte(input logic [7:0] a);
    case (map_addr(a))
      OFS_LOCAL_TEMP: read_byte = local_reg;
      OFS_REM_MSB: read_byte = rem_reg[12:5];
      OFS_ALERT: read_byte = alert_flags_out;
      OFS_CONFIG: read_byte = regs_reg.config_r;
      OFS_RATE: read_byte = regs_reg.rate;
      OFS_LOCAL_HI: read_byte = regs_reg.local_hi;
      OFS_REM_HI: read_byte = regs_reg.rem_hi;
      OFS_REM_LO: read_byte = regs_reg.rem_lo;
      OFS_REM_LSB: read_byte = {rem_reg[4:0], 3'h0};
      OFS_OFFSET: read_byte = regs_reg.offset;
      OFS_FILTER: read_byte = regs_reg.filter;
      default: read_byte = 8'h00;
    endcase
  endfunction : read_byte

  // serial state machine
  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    rw_next = rw_reg;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    tmo_next = (!scl_in || !sda_in) ? ((tmo_reg == '1) ? tmo_reg : tmo_reg + 21'h1) : 21'h0;
    if (tmo_hit) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
      tmo_next = 21'h0;
    end else if (start_c) begin
      state_next = ST_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop_c) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_CMD, ST_WDATA, ST_IGNORE: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_in};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == 4'h8) begin
            bit_next = 4'h0;
            case (state_reg)
              ST_ADDR: begin
                if (shift_reg[7:1] == SLAVE_ADDR) begin
                  state_next = ST_ADDR_ACK;
                  oe_next = 1'b1;
                  rw_next = shift_reg[0];
                end else begin
                  state_next = ST_IDLE;
                end
              end
              ST_CMD: begin
                ptr_next = shift_reg;
                state_next = ST_CMD_ACK;
                oe_next = 1'b1;
              end
              ST_WDATA: begin
                wr_stb = 1'b1;
                state_next = ST_WDATA_ACK;
                oe_next = 1'b1;
              end
              default: state_next = ST_IGNORE;
            endcase
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_next = 4'h0;
            if (rw_reg) begin
              shift_next = read_byte(ptr_reg);
              rd_stb = 1'b1;
              oe_next = ~shift_next[7];
              state_next = ST_RDATA;
            end else begin
              oe_next = 1'b0;
              state_next = ST_CMD;
            end
          end
        end
        ST_CMD_ACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            state_next = ST_WDATA;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            state_next = ST_IGNORE;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_reg == 4'h7) begin
              oe_next = 1'b0;
              state_next = ST_RDATA_ACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = ~shift_next[7];
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            shift_next[0] = sda_in;
          end else if (scl_fall) begin
            bit_next = 4'h0;
            if (!shift_reg[0]) begin
              shift_next = read_byte(ptr_reg);
              rd_stb = 1'b1;
              oe_next = ~shift_next[7];
              state_next = ST_RDATA;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      tmo_reg <= 21'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (clk_en_in) begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      rw_reg <= rw_next;
      tmo_reg <= tmo_next;
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // register bank; read-only and reserved targets fall through untouched
  always_comb begin
    regs_next = regs_reg;
    one_shot_next = 1'b0;
    if (wr_stb) begin
      case (map_addr(ptr_reg))
        OFS_CONFIG: regs_next.config_r = shift_reg & MASK_CONFIG;
        OFS_RATE: regs_next.rate = shift_reg & MASK_RATE;
        OFS_LOCAL_HI: regs_next.local_hi = shift_reg;
        OFS_REM_HI: regs_next.rem_hi = shift_reg;
        OFS_REM_LO: regs_next.rem_lo = shift_reg;
        OFS_OFFSET: regs_next.offset = shift_reg;
        OFS_FILTER: regs_next.filter = shift_reg & MASK_FILTER;
        OFS_ONE_SHOT: one_shot_next = regs_reg.config_r[CFG_STANDBY];
        default: regs_next = regs_reg;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      regs_reg <= '{RST_CONFIG, RST_RATE, RST_LOCAL_HI, RST_REM_HI, RST_REM_LO, RST_OFFSET, RST_FILTER};
      one_shot_reg <= 1'b0;
    end else if (clk_en_in) begin
      regs_reg <= regs_next;
      one_shot_reg <= one_shot_next;
    end
  end

  // remote filter: first-order average; the floored step can settle a steady input up to 3 accumulator counts low
  logic [1:0] fsel;
  logic signed [14:0] x15;
  logic signed [15:0] diff, step;
  always_comb begin
    fsel = regs_reg.filter[FLT_SEL_LO +: 2];
    x15 = $signed({remote_raw_in, 4'h0});
    diff = 16'(x15) - 16'(acc_reg);
    if (fsel == FILT_ENH && diff > FILT_CLIP) diff = FILT_CLIP;
    if (fsel == FILT_ENH && diff < -FILT_CLIP) diff = -FILT_CLIP;
    step = diff >>> 2;
    local_next = local_reg;
    acc_next = acc_reg;
    rem_next = rem_reg;
    if (conversion_interval_code_done_in) begin
      local_next = local_temp_in;
      if (fsel == FILT_STD || fsel == FILT_ENH) begin
        acc_next = acc_reg + step[14:0];
        rem_next = acc_next[14:2];
      end else begin
        acc_next = x15;
        rem_next = {remote_raw_in, 2'h0};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      local_reg <= 8'h00;
      acc_reg <= 15'sh0;
      rem_reg <= 13'h0;
    end else if (clk_en_in) begin
      local_reg <= local_next;
      acc_reg <= acc_next;
      rem_reg <= rem_next;
    end
  end

  // fault queue, one run counter per compared limit
  assign cond[0] = $signed(local_next) > $signed(regs_reg.local_hi);
  assign cond[1] = $signed(rem_next[12:5]) > $signed(regs_reg.rem_hi);
  assign cond[2] = $signed(rem_next[12:5]) < $signed(regs_reg.rem_lo);
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_fq
      always_comb begin
        cnt_next[i] = cnt_reg[i];
        if (conversion_interval_code_done_in) begin
          cnt_next[i] = !cond[i] ? 2'h0 : (cnt_reg[i] == FQ_COUNT) ? FQ_COUNT : cnt_reg[i] + 2'h1;
        end
        hit[i] = conversion_interval_code_done_in && cond[i] &&
                 (!regs_reg.config_r[CFG_FAULT_QUEUE] || cnt_next[i] == FQ_COUNT);
      end
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          cnt_reg[i] <= 2'h0;
        end else if (clk_en_in) begin
          cnt_reg[i] <= cnt_next[i];
        end
      end
    end
  endgenerate

  // sticky flags clear when the status byte is loaded; a new event wins
  always_comb begin
    flag_next = flag_reg;
    if (rd_stb && map_addr(ptr_reg) == OFS_ALERT) flag_next = 4'h0;
    flag_next = flag_next | {conversion_interval_code_done_in & diode_fault_in, hit};
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      flag_reg <= 4'h0;
    end else if (clk_en_in) begin
      flag_reg <= flag_next;
    end
  end

  always_comb begin
    alert_flags_out = 8'h00;
    alert_flags_out[ALT_BUSY] = busy_in;
    alert_flags_out[ALT_LOCAL_HI] = flag_reg[0];
    alert_flags_out[ALT_REM_HI] = flag_reg[1];
    alert_flags_out[ALT_REM_LO] = flag_reg[2];
    alert_flags_out[ALT_DIODE] = flag_reg[3];
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = oe_reg;
  assign one_shot_out = one_shot_reg;
  assign standby_out = regs_reg.config_r[CFG_STANDBY];
  assign regs_out = regs_reg;

  sequence s_addr_ack;
    state_reg == ST_ADDR_ACK;
  endsequence
  sequence s_nack_fall;
    clk_en_in && state_reg == ST_RDATA_ACK && scl_fall && shift_reg[0] && !start_c && !stop_c && !tmo_hit;
  endsequence

  a_ack_drive: assert property (@(posedge clk_in) disable iff (reset_in) s_addr_ack |-> oe_reg)
    else $error("address ack not driven");
  a_timeout_idle: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && tmo_hit |=> state_reg == ST_IDLE && !oe_reg)
    else $error("timeout did not idle bus");
  a_start_restart: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && start_c && !tmo_hit |=> state_reg == ST_ADDR && bit_reg == 4'h0)
    else $error("start not recognised");
  a_nack_end: assert property (@(posedge clk_in) disable iff (reset_in)
    s_nack_fall |=> state_reg == ST_IDLE && !oe_reg)
    else $error("nack did not end read");
  a_extra_nack: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg == ST_IGNORE |-> !oe_reg)
    else $error("extra data byte acked");
  a_oneshot_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && one_shot_out |=> !one_shot_out)
    else $error("one-shot longer than a cycle");
  a_oneshot_zero: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && rd_stb && map_addr(ptr_reg) == OFS_ONE_SHOT |=> shift_reg == 8'h00 && oe_reg)
    else $error("one-shot read not zero");
  a_unfilt_lsb: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && conversion_interval_code_done_in && fsel != FILT_STD && fsel != FILT_ENH |=> rem_reg[1:0] == 2'h0)
    else $error("unused remote bits not zero");
  a_fault_queue: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && regs_reg.config_r[CFG_FAULT_QUEUE] && conversion_interval_code_done_in && cnt_reg[2] < 2'h2 && !flag_reg[2]
    |=> !flag_reg[2])
    else $error("remote low flagged early");
endmodule : sti_regif

// ===== verif/sti_host.sv
/*
  bus master model for the thermal sensor front end: start, stop, bytes and register transfers.
  assumes the bench resolves the open-drain data wire with a pull-up and that the clock line idles high.
*/
`timescale 1ns/1ps
module sti_host import sti_pkg::*; (
  // clock
  input wire logic clk_in,
  // bus
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // levels move just after an edge and stand four cycles, so the slave sees every phase
  task automatic step(input logic c, input logic d);
    @(posedge clk_in);
    scl_out <= c;
    sda_low_out <= ~d;
    repeat (3) @(posedge clk_in);
  endtask : step

  task automatic start_c();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start_c

  task automatic stop_c();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop_c

  // data changes only while the clock is low; the wire is read in the high phase
  task automatic bit_c(input logic d, output logic q);
    step(1'b0, d);
    step(1'b1, d);
    q = sda_in;
    step(1'b0, d);
  endtask : bit_c

  task automatic tx(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_c(b[i], q);
    bit_c(1'b1, ack);
  endtask : tx

  task automatic rx(input logic nack, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, q);
      b[i] = q;
    end
    bit_c(nack, q);
  endtask : rx

  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic [2:0] k);
    start_c();
    tx({a, 1'b0}, k[2]);
    tx(c, k[1]);
    tx(d, k[0]);
    stop_c();
  endtask : wr

  // fan setup lives outside this block, so reads may follow reset at once
  task automatic rd(input logic [7:0] c, input int n, output logic [7:0] d);
    logic k;
    start_c();
    tx({SLAVE_ADDR, 1'b0}, k);
    tx(c, k);
    start_c();
    tx({SLAVE_ADDR, 1'b1}, k);
    for (int i = n; i > 0; i--) rx(i == 1, d);
    stop_c();
  endtask : rd
endmodule : sti_host

// ===== verif/tb_top.sv
/*
  self-checking bench of the thermal sensor register front end with a bus master model.
  assumes the design's own assertions guard the cycle timing; this bench checks values.
*/
`timescale 1ns/1ps
module tb_top import sti_pkg::*; ();
  localparam int TO = 1000;
  logic clk_in = 1'b0;
  logic reset_in, clk_en_in, conversion_interval_code_done_in, busy_in, diode_fault_in;
  logic [7:0] local_temp_in, alert_flags_out, v, m;
  logic [10:0] remote_raw_in, x;
  logic sda_out, sda_oe_out, one_shot_out, standby_out, scl_w, host_low, sda_w, q;
  logic [2:0] k;
  sti_regs_t regs_out;
  int err_count = 0, compares = 0, seed = 80, shots = 0, dv, lim, n;
  // only locations of this block are visited
  logic [7:0] ofs [16] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
    8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h11, 8'hbf};
  logic [7:0] alt [16] = '{8'h00, 8'h09, 8'h0a, 8'h0b, 8'h06, 8'h0d, 8'h0e, 8'h03,
    8'h04, 8'h05, 8'h0c, 8'h07, 8'h08, 8'h0f, 8'h11, 8'hbf};
  logic [7:0] rst [16] = '{8'h00, 8'h00, 8'h08, 8'h46, 8'h00, 8'h69, 8'h00, 8'h00,
    8'h08, 8'h46, 8'h00, 8'h69, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk [16] = '{8'h00, 8'he7, 8'h0f, 8'hff, 8'h00, 8'hff, 8'hff, 8'he7,
    8'h0f, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff, 8'h07};

  // open-drain wire with pull-up
  assign sda_w = ~(host_low | (sda_oe_out & ~sda_out));

  sti_regif #(.TIMEOUT(TO)) sti_regif_i (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .local_temp_in(local_temp_in), .remote_raw_in(remote_raw_in), .conversion_interval_code_done_in(conversion_interval_code_done_in),
    .busy_in(busy_in), .diode_fault_in(diode_fault_in), .one_shot_out(one_shot_out),
    .standby_out(standby_out), .regs_out(regs_out), .alert_flags_out(alert_flags_out));
  sti_host sti_host_i (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl_w), .sda_low_out(host_low));

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (one_shot_out === 1'b1) shots++;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // status byte expected from the flag positions; busy is live, the rest sticky
  function automatic logic [7:0] exp_alert(input logic b, input logic lh, input logic rh, input logic rl,
    input logic df);
    exp_alert = 8'h00;
    exp_alert[ALT_BUSY] = b;
    exp_alert[ALT_LOCAL_HI] = lh;
    exp_alert[ALT_REM_HI] = rh;
    exp_alert[ALT_REM_LO] = rl;
    exp_alert[ALT_DIODE] = df;
  endfunction : exp_alert

  task automatic rdchk(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] d;
    sti_host_i.rd(c, 1, d);
    check($sformatf("reg %h", c), d, e);
  endtask : rdchk

  // ends on a falling edge so the flags updated by the last pulse have landed
  task automatic temps(input logic [7:0] lt, input logic [10:0] rr, input int cnt);
    @(posedge clk_in);
    local_temp_in <= lt;
    remote_raw_in <= rr;
    repeat (cnt) begin
      @(posedge clk_in);
      conversion_interval_code_done_in <= 1'b1;
      @(posedge clk_in);
      conversion_interval_code_done_in <= 1'b0;
    end
    @(negedge clk_in);
  endtask : temps

  initial begin
    repeat (90000) @(posedge clk_in);
    err_count++;
    conclude();
  end

  initial begin
    reset_in = 1'b1;
    clk_en_in = 1'b1;
    conversion_interval_code_done_in = 1'b0;
    busy_in = 1'b0;
    diode_fault_in = 1'b0;
    local_temp_in = 8'h19;
    remote_raw_in = 11'h140;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    foreach (ofs[i]) rdchk(ofs[i], rst[i]);
    sti_host_i.wr(7'h2a, OFS_CONFIG, 8'hff, k);
    check("foreign address acks", {5'h00, k}, 8'h07);
    check("config", regs_out.config_r, 8'h00);
    foreach (ofs[i]) begin
      v = 8'($random(seed));
      sti_host_i.wr(SLAVE_ADDR, ofs[i], v, k);
      check("write acks", {5'h00, k}, 8'h00);
      rdchk(alt[i], v & msk[i]);
    end
    rdchk(8'h0c, 8'h00);
    // a second data byte is refused and leaves the first in place
    sti_host_i.wr(SLAVE_ADDR, OFS_RATE, 8'h05, k);
    sti_host_i.start_c();
    sti_host_i.tx({SLAVE_ADDR, 1'b0}, q);
    sti_host_i.tx(OFS_LOCAL_HI, q);
    sti_host_i.tx(8'h11, q);
    sti_host_i.tx(8'h22, q);
    check("extra byte ack", {7'h00, q}, 8'h01);
    sti_host_i.stop_c();
    check("local limit", regs_out.local_hi, 8'h11);
    sti_host_i.start_c();
    sti_host_i.tx({SLAVE_ADDR, 1'b0}, q);
    sti_host_i.tx(OFS_RATE, q);
    repeat (3) sti_host_i.bit_c(1'b1, q);
    sti_host_i.wr(SLAVE_ADDR, OFS_LOCAL_HI, 8'h33, k);
    check("rate", regs_out.rate, 8'h05);
    check("local limit", regs_out.local_hi, 8'h33);
    sti_host_i.rd(OFS_LOCAL_HI, 3, v);
    check("acked read", v, 8'h33);
    // stall in mid-read with the slave pulling data low
    sti_host_i.start_c();
    sti_host_i.tx({SLAVE_ADDR, 1'b1}, q);
    check("slave drives", {7'h00, sda_oe_out}, 8'h01);
    repeat (TO + 100) @(posedge clk_in);
    check("released", {7'h00, sda_oe_out}, 8'h00);
    sti_host_i.step(1'b1, 1'b1);
    rdchk(OFS_RATE, 8'h05);
    for (int c = 0; c < 4; c++) begin
      x = 11'($random(seed)) & 11'h3ff;
      remote_raw_in <= x;
      sti_host_i.wr(SLAVE_ADDR, OFS_FILTER, 8'(c * 2), k);
      // clipped slewing across the whole range needs a few hundred conversions
      temps(local_temp_in, x, 320);
      sti_host_i.rd(OFS_REM_MSB, 1, m);
      sti_host_i.rd(OFS_REM_LSB, 1, v);
      dv = int'({m, v[7:3]}) - int'({x, 2'b00});
      lim = (c == 1 || c == 3) ? 1 : 0;
      check("unused bits", {5'h00, v[2:0]}, 8'h00);
      check("filter error", {7'h00, dv >= -lim && dv <= lim}, 8'h01);
    end
    sti_host_i.wr(SLAVE_ADDR, OFS_FILTER, 8'h00, k);
    sti_host_i.wr(SLAVE_ADDR, OFS_CONFIG, 8'h00, k);
    sti_host_i.wr(SLAVE_ADDR, OFS_LOCAL_HI, 8'h46, k);
    sti_host_i.wr(SLAVE_ADDR, OFS_REM_HI, 8'h3f, k);
    sti_host_i.wr(SLAVE_ADDR, OFS_REM_LO, 8'h30, k);
    temps(8'h19, 11'h1c0, 1);
    sti_host_i.rd(OFS_ALERT, 1, v);
    temps(8'h50, 11'h140, 1);
    check("flags", alert_flags_out, 8'h48);
    rdchk(OFS_ALERT, 8'h48);
    check("flags", alert_flags_out, 8'h00);
    temps(8'h19, 11'h1c0, 1);
    sti_host_i.wr(SLAVE_ADDR, OFS_CONFIG, 8'h01, k);
    temps(8'h50, 11'h140, 2);
    temps(8'h19, 11'h1c0, 1);
    temps(8'h50, 11'h140, 2);
    check("queued flags", alert_flags_out, 8'h00);
    busy_in <= 1'b1;
    temps(8'h50, 11'h140, 1);
    check("queued flags", alert_flags_out, 8'hc8);
    sti_host_i.wr(SLAVE_ADDR, OFS_CONFIG_MIR, 8'h40, k);
    check("standby", {7'h00, standby_out}, 8'h01);
    for (int s = 0; s < 2; s++) begin
      n = shots;
      sti_host_i.wr(SLAVE_ADDR, OFS_ONE_SHOT, 8'(200 + s), k);
      check("one shot pulses", 8'(shots - n), 8'(1 - s));
      sti_host_i.wr(SLAVE_ADDR, OFS_CONFIG, 8'h00, k);
    end
    // a frozen block ignores conversions; once running, remote high and diode fault latch
    @(posedge clk_in);
    clk_en_in <= 1'b0;
    temps(8'h19, 11'h240, 2);
    check("frozen flags", alert_flags_out, exp_alert(1'b1, 1'b1, 1'b0, 1'b1, 1'b0));
    @(posedge clk_in);
    clk_en_in <= 1'b1;
    diode_fault_in <= 1'b1;
    temps(8'h19, 11'h240, 1);
    check("high and diode flags", alert_flags_out, exp_alert(1'b1, 1'b1, 1'b1, 1'b1, 1'b1));
    conclude();
  end
endmodule : tb_top
